/* src/pfs_bank.sv */
// Pad function-select bank: eight masked-write select registers on AXI4-Lite.
// Assumes bus inputs synchronous to aclk; pad_sel drives the pad multiplexers.
`timescale 1ns/1ns

// What this block does
// - A write updates select bit i only where bit i+16 of the written word is one.
// - A select bit whose mask bit is written zero keeps its previous value.
// - The upper sixteen mask bits are never stored and read back as zero.
// - A single-bit select picks GPIO at zero and its alternate at one; odd bit reads zero.
// - A two-bit select picks GPIO for 00, alternates one and two for 01, 10, and for 11 alternate three where the pad defines one, else GPIO.
// - Every select field resets to zero so all pads start as GPIO.
// - Each register serves eight pads, pad n in bits 2n+1 down to 2n.
// - Single-function pads use only the even bit while multi-function pads use the pair.
// - The group registers decode at consecutive word offsets from the bank base.
module pfs_bank
  import pfs_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output pfs_group_s [NREG-1:0] pad_sel
);

  // ==========================================================================
  // Helpers
  function automatic logic [NREG-1:0] reg_hit(input logic [ADDR_W-1:0] addr);
    reg_hit = '0;
    for (int k = 0; k < NREG; k++) begin
      if (addr[ADDR_W-1:2] == REG_OFFSET[k][ADDR_W-1:2]) begin
        reg_hit[k] = 1'b1;
      end
    end
  endfunction

  function automatic logic [1:0] fn_code(input logic [1:0] raw, input logic third);
    if (raw == PFS_FN_ALT3 && !third) begin
      fn_code = PFS_FN_GPIO;
    end else begin
      fn_code = raw;
    end
  endfunction

  // ==========================================================================
  // State
  logic aw_held_q, aw_held_d;
  logic [ADDR_W-1:0] aw_addr_q, aw_addr_d;
  logic w_held_q, w_held_d;
  logic [31:0] w_data_q, w_data_d;
  logic [3:0] w_strb_q, w_strb_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  logic [NREG-1:0][SEL_W-1:0] sel_q, sel_d;
  pfs_group_s [NREG-1:0] pad_q, pad_d;

  logic do_write;
  logic [NREG-1:0] wr_hit;
  logic [NREG-1:0] rd_hit;
  logic [15:0] lane_en;
  logic [NREG-1:0][15:0] en_w;

  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready = !w_held_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign pad_sel = pad_q;

  assign do_write = aw_held_q && w_held_q && !bvalid_q;
  assign wr_hit = reg_hit(aw_addr_q);
  assign rd_hit = reg_hit(s_axi_araddr);
  // A select bit is written only when its byte lane and its mask's byte lane are strobed
  assign lane_en = {{8{w_strb_q[3] & w_strb_q[1]}}, {8{w_strb_q[2] & w_strb_q[0]}}};

  // ==========================================================================
  // Next-state logic
  always_comb begin
    aw_held_d = aw_held_q;
    aw_addr_d = aw_addr_q;
    w_held_d = w_held_q;
    w_data_d = w_data_q;
    w_strb_d = w_strb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    sel_d = sel_q;

    if (s_axi_awvalid && s_axi_awready) begin
      aw_held_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_held_d = 1'b1;
      w_data_d = s_axi_wdata;
      w_strb_d = s_axi_wstrb;
    end

    for (int k = 0; k < NREG; k++) begin
      en_w[k] = w_data_q[31:MASK_LSB] & WR_MASK[k] & lane_en;
    end

    if (do_write) begin
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = (|wr_hit) ? RESP_OKAY : RESP_SLVERR;
      for (int k = 0; k < NREG; k++) begin
        if (wr_hit[k]) begin
          // Mask bits only qualify the write and are dropped here
          sel_d[k] = (sel_q[k] & ~en_w[k]) | (w_data_q[15:0] & en_w[k]);
        end
      end
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end

    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rdata_d = '0;
      rresp_d = (|rd_hit) ? RESP_OKAY : RESP_SLVERR;
      for (int k = 0; k < NREG; k++) begin
        if (rd_hit[k]) begin
          rdata_d[15:0] = sel_q[k];
        end
      end
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end

    for (int k = 0; k < NREG; k++) begin
      for (int p = 0; p < PADS; p++) begin
        pad_d[k].pad[p] = fn_code(sel_d[k][2*p +: 2], THIRD_FN[k][p]);
      end
    end
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= '0;
      w_held_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
      sel_q <= {NREG{SEL_RESET}};
      pad_q <= '0;
    end else begin
      aw_held_q <= aw_held_d;
      aw_addr_q <= aw_addr_d;
      w_held_q <= w_held_d;
      w_data_q <= w_data_d;
      w_strb_q <= w_strb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      sel_q <= sel_d;
      pad_q <= pad_d;
    end
  end

  // ==========================================================================
  // Checks
  generate
    for (genvar g = 0; g < NREG; g++) begin : g_chk
      a_mask_sets_bits: assert property (
        @(posedge aclk) disable iff (!aresetn)
        do_write && wr_hit[g] |=>
          ((sel_q[g] ^ $past(w_data_q[15:0])) & $past(en_w[g])) == 16'h0000)
        else $error("Enabled select bit not written");

      a_mask_blocks_write: assert property (
        @(posedge aclk) disable iff (!aresetn)
        do_write && wr_hit[g] |=> ((sel_q[g] ^ $past(sel_q[g])) & ~$past(en_w[g])) == 16'h0000)
        else $error("Masked select bit changed");

      a_reserved_zero: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (sel_q[g] & ~WR_MASK[g]) == 16'h0000)
        else $error("Reserved select bit set");

      a_read_returns_sel: assert property (
        @(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready && rd_hit[g] |=>
          s_axi_rvalid && s_axi_rdata == {16'h0000, $past(sel_q[g])})
        else $error("Read data differs from the stored selects");

      a_sel_only_on_hit: assert property (
        @(posedge aclk) disable iff (!aresetn)
        !(do_write && wr_hit[g]) |=> sel_q[g] == $past(sel_q[g]))
        else $error("Select register changed without a write to it");

      // A select byte moves only when its own lane and its mask lane are strobed
      a_high_lane_gate: assert property (
        @(posedge aclk) disable iff (!aresetn)
        do_write && wr_hit[g] && !(w_strb_q[1] && w_strb_q[3]) |=>
          sel_q[g][15:8] == $past(sel_q[g][15:8]))
        else $error("Unstrobed high select byte changed");

      a_low_lane_gate: assert property (
        @(posedge aclk) disable iff (!aresetn)
        do_write && wr_hit[g] && !(w_strb_q[0] && w_strb_q[2]) |=>
          sel_q[g][7:0] == $past(sel_q[g][7:0]))
        else $error("Unstrobed low select byte changed");

      a_write_ok_hit: assert property (
        @(posedge aclk) disable iff (!aresetn)
        do_write && wr_hit[g] |=> s_axi_bvalid && s_axi_bresp == RESP_OKAY)
        else $error("Mapped write not answered OKAY");

      for (genvar p = 0; p < PADS; p++) begin : g_pad
        a_pad_follows_sel: assert property (
          @(posedge aclk) disable iff (!aresetn)
          $stable(sel_q[g]) && sel_q[g][2*p +: 2] != PFS_FN_ALT3 |->
            pad_q[g].pad[p] == sel_q[g][2*p +: 2])
          else $error("Pad code differs from its select field");

        a_no_third_fallback: assert property (
          @(posedge aclk) disable iff (!aresetn)
          sel_q[g][2*p +: 2] == PFS_FN_ALT3 && !THIRD_FN[g][p] |->
            pad_q[g].pad[p] == PFS_FN_GPIO)
          else $error("Undefined code did not fall back to GPIO");

        a_third_kept: assert property (
          @(posedge aclk) disable iff (!aresetn)
          sel_q[g][2*p +: 2] == PFS_FN_ALT3 && THIRD_FN[g][p] |->
            pad_q[g].pad[p] == PFS_FN_ALT3)
          else $error("Defined third function not passed to the pad");

        a_single_no_alt2: assert property (
          @(posedge aclk) disable iff (!aresetn)
          !WR_MASK[g][2*p+1] |-> pad_q[g].pad[p][1] == 1'b0)
          else $error("Single-function pad shows a second function");
      end
    end
  endgenerate

  a_reset_gpio: assert property (
    @(posedge aclk)
    !aresetn |=> pad_q == '0 && sel_q == '0)
    else $error("Pads not GPIO after reset");

  a_read_mask_zero: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready && (|rd_hit) |=>
      rvalid_q && rdata_q[31:16] == 16'h0000 && rresp_q == RESP_OKAY)
    else $error("Read answer wrong");

  a_write_decode: assert property (
    @(posedge aclk) disable iff (!aresetn)
    do_write |=> bvalid_q && (bresp_q == RESP_SLVERR) == ($past(wr_hit) == '0))
    else $error("Write response does not match decode");

  a_unmapped_read: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready && !(|rd_hit) |=>
      s_axi_rdata == 32'h00000000 && s_axi_rresp == RESP_SLVERR)
    else $error("Unmapped read not refused");

  // Pads move only together with their select register
  a_pad_only_on_write: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !do_write |=> pad_q == $past(pad_q))
    else $error("Pad code changed without a write");

  // Offsets are distinct, so no address may select two registers
  a_hit_one_hot: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $onehot0(wr_hit) && $onehot0(rd_hit))
    else $error("Address decodes to more than one register");

endmodule

/* src/pfs_pkg.sv */
// Constants, types and register map of the pad function-select bank.
// Assumes one system clock and a 12-bit byte address window for the bank.
package pfs_pkg;

  // ==========================================================================
  // Geometry
  localparam int NREG = 8;
  localparam int PADS = 8;
  localparam int ADDR_W = 12;
  localparam int MASK_LSB = 16;
  localparam int SEL_W = 16;

  // ==========================================================================
  // Register byte offsets
  localparam logic [11:0] OFF_BANK1_B = 12'h0BC;
  localparam logic [11:0] OFF_BANK1_C = 12'h0C0;
  localparam logic [11:0] OFF_BANK1_D = 12'h0C4;
  localparam logic [11:0] OFF_BANK2_A = 12'h0C8;
  localparam logic [11:0] OFF_BANK2_B = 12'h0CC;
  localparam logic [11:0] OFF_BANK2_C = 12'h0D0;
  localparam logic [11:0] OFF_BANK2_D = 12'h0D4;
  localparam logic [11:0] OFF_BANK3_A = 12'h0D8;
  localparam logic [NREG-1:0][11:0] REG_OFFSET = {OFF_BANK3_A, OFF_BANK2_D, OFF_BANK2_C,
    OFF_BANK2_B, OFF_BANK2_A, OFF_BANK1_D, OFF_BANK1_C, OFF_BANK1_B};

  // ==========================================================================
  // Writable select bits per register; 0x5555 marks single-bit pads only
  localparam logic [15:0] WM_BANK1_B = 16'h5555;
  localparam logic [15:0] WM_BANK1_C = 16'hFFFF;
  localparam logic [15:0] WM_BANK1_D = 16'h555F;
  localparam logic [15:0] WM_BANK2_A = 16'hFFFF;
  localparam logic [15:0] WM_BANK2_B = 16'hFFFF;
  localparam logic [15:0] WM_BANK2_C = 16'hFFFF;
  localparam logic [15:0] WM_BANK2_D = 16'h555D;
  localparam logic [15:0] WM_BANK3_A = 16'h5555;
  localparam logic [NREG-1:0][15:0] WR_MASK = {WM_BANK3_A, WM_BANK2_D, WM_BANK2_C,
    WM_BANK2_B, WM_BANK2_A, WM_BANK1_D, WM_BANK1_C, WM_BANK1_B};

  // ==========================================================================
  // Pads that define a third function (one bit per pad)
  localparam logic [NREG-1:0][7:0] THIRD_FN = {8'h00, 8'h00, 8'hFF, 8'hF0, 8'h00,
    8'h00, 8'h01, 8'h00};

  // ==========================================================================
  // Reset values and bus answers
  localparam logic [15:0] SEL_RESET = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    PFS_FN_GPIO = 2'b00,
    PFS_FN_ALT1 = 2'b01,
    PFS_FN_ALT2 = 2'b10,
    PFS_FN_ALT3 = 2'b11
  } pfs_fn_e;

  typedef struct packed {
    logic [PADS-1:0][1:0] pad;
  } pfs_group_s;

endpackage

/* verif/pfs_bank_test.sv */
// Self-checking bench of the pad function-select bank over AXI4-Lite.
// Assumes pfs_pkg and pfs_bank are compiled first; clock 50 MHz.
`timescale 1ns/1ns
module pfs_bank_test;
  import pfs_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0;
  logic [ADDR_W-1:0] araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  pfs_group_s [NREG-1:0] pad_sel;
  int n_errors = 0;
  int compares = 0;

  pfs_bank DUT (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pad_sel(pad_sel));

  // ==========================================================================
  // Clock and watchdog
  initial forever #10 aclk = ~aclk;
  initial begin
    #100000;
    n_errors++;
    close_out();
  end

  // ==========================================================================
  // Bus tasks; handshakes sampled at the falling edge, driven at the rising
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_hs, w_hs, done;
    done = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (done !== 1'b1) begin
      @(negedge aclk);
      aw_hs = awvalid & awready;
      w_hs = wvalid & wready;
      done = bvalid & bready;
      r = bresp;
      @(posedge aclk);
      if (aw_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_hs, done;
    done = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (done !== 1'b1) begin
      @(negedge aclk);
      ar_hs = arvalid & arready;
      done = rvalid & rready;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ar_hs) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask

  // Write a word, then read it back and look at the pad outputs
  task automatic wcheck(input int i, input logic [31:0] d, input logic [15:0] rv,
      input logic [15:0] pv);
    logic [31:0] q;
    logic [1:0] r;
    wr(REG_OFFSET[i], d, r);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
    rd(REG_OFFSET[i], q, r);
    chk(q, {16'h0000, rv});
    chk({16'h0000, pad_sel[i]}, {16'h0000, pv});
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    logic [31:0] q;
    logic [1:0] r;
    for (int i = 0; i < NREG; i++) begin
      rd(REG_OFFSET[i], q, r);
      chk(q, 32'h00000000);
      chk({16'h0000, pad_sel[i]}, 32'h00000000);
    end
    $display("reset values test done");
  endtask

  task automatic t_mask();
    wcheck(1, 32'hFFFF1234, 16'h1234, 16'h1204);
    wcheck(1, 32'h00FFFFFF, 16'h12FF, 16'h1203);
    wcheck(1, 32'h0000FFFF, 16'h12FF, 16'h1203);
    wcheck(5, 32'hFFFFFFFF, 16'hFFFF, 16'hFFFF);
    wcheck(6, 32'hFFFFFFFF, 16'h555D, 16'h5551);
    $display("masked write test done");
  endtask

  task automatic t_single();
    wcheck(0, 32'hFFFFFFFF, 16'h5555, 16'h5555);
    wcheck(0, 32'h00010000, 16'h5554, 16'h5554);
    wcheck(2, 32'hFFFFFFFF, 16'h555F, 16'h5550);
    $display("single-bit field test done");
  endtask

  task automatic t_unmapped();
    logic [31:0] q;
    logic [1:0] r;
    wr(12'h000, 32'hFFFFFFFF, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    rd(12'h0DC, q, r);
    chk(q, 32'h00000000);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    $display("unmapped address test done");
  endtask

  task automatic t_strobe();
    wstrb <= 4'h5;
    wcheck(3, 32'hFFFFFFFF, 16'h00FF, 16'h0000);
    wstrb <= 4'hA;
    wcheck(3, 32'hFFFF5555, 16'h55FF, 16'h5500);
    wstrb <= 4'hF;
    wcheck(4, 32'hFFFFFFFF, 16'hFFFF, 16'hFF00);
    wcheck(7, 32'hFFFFAAAA, 16'h0000, 16'h0000);
    wcheck(7, 32'hFFFF5555, 16'h5555, 16'h5555);
    $display("strobe and remaining group test done");
  endtask

  // ==========================================================================
  // Main sequence and verdict
  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_mask();
    t_single();
    t_unmapped();
    t_strobe();
    close_out();
  end
endmodule
